// [src/pei_pkg.sv]
// package of the event status and interrupt block: register offsets, field layout, reset values.
// assumes a 16-bit management register port with 5-bit register addresses.
package pei_pkg;

	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam logic [4:0] ADDR_INTERRUPT_CONTROL     = 5'h11;
	localparam logic [4:0] ADDR_EVENT_STATUS_ENABLE   = 5'h12;
	localparam logic [4:0] ADDR_REGISTER_PAGE_SELECT  = 5'h13;
	localparam logic [4:0] ADDR_FALSE_CARRIER_COUNT   = 5'h14;

	// ----------------------------------------
	// field layout
	// ----------------------------------------
	localparam int NUM_EVENTS          = 8;
	localparam int PENDING_LSB         = 8;
	localparam int CTRL_INT_OE_BIT     = 0;
	localparam int CTRL_GLOBAL_EN_BIT  = 1;
	localparam int CTRL_TEST_FORCE_BIT = 2;
	localparam int PAGE_WIDTH          = 2;
	localparam int COUNT_WIDTH         = 8;
	// event index inside the 8-bit pending and enable fields
	localparam int EV_RX_ERROR_HALF    = 0;
	localparam int EV_FALSE_CARR_HALF  = 1;
	localparam int EV_LINK_CHANGE      = 5;

	// ----------------------------------------
	// reset values and page codes
	// ----------------------------------------
	localparam logic [15:0] REG_RESET        = 16'h0000;
	localparam logic [7:0]  COUNT_MAX        = 8'hFF;
	localparam logic [1:0]  PAGE_EXTENDED_0  = 2'h0;
	localparam logic [1:0]  PAGE_RESERVED    = 2'h1;
	localparam logic [1:0]  PAGE_LINK_DIAG   = 2'h2;

	// events from the link logic, one-cycle pulses, same clock
	typedef struct packed {
		logic link_quality;
		logic energy_detect;
		logic link_change;
		logic speed_change;
		logic duplex_change;
		logic autoneg_done;
	} pei_events_s;

	// management register access
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} pei_mgmt_req_s;

endpackage : pei_pkg

// [src/pei_event_irq.sv]
// event status flags, interrupt control, page select and false-carrier counter of one port.
// assumes the management serial engine hands over single-cycle register reads and writes on this clock;
// event pulses come from logic on the same clock, the shared pin is synchronised here.
// Function
// RULE1: flag an event's status bit if it occurred since the last status read
// RULE2: interrupt on event only with its enable and the control enables set
// RULE3: status flags set even when the event's interrupt is disabled
// RULE4: link quality bit 15, energy detect bit 14, link change bit 13
// RULE5: speed change bit 12, duplex change bit 11, autoneg done bit 10
// RULE6: false carrier half-full bit 9, receive error half-full bit 8
// RULE7: pending flags read back then clear on that read; reset to zero
// RULE8: read-write enables bits 7..0 in pending order, reset to zero
// RULE9: two-bit page field bits 1:0 selects bank at 14h..1Fh; 1 reserved
// RULE10: page register bits 15:2 ignore writes and read zero
// RULE11: 8-bit false carrier count increments once per false carrier event
// RULE12: false carrier count sticks at FFh instead of wrapping
// RULE13: count resets zero, read-only, clears on read, bits 15:8 read zero
// RULE14: global enable bit 1 gates all event interrupts
// RULE15: test bit 2 keeps interrupt asserted while set
// RULE16: bit 0 makes shared pin interrupt output, else power-down input
// RULE17: counter half-full when its top bit becomes set, sets pending flag
// RULE18: interrupt stays while any enabled pending flag set, drops once cleared
`timescale 1ns/1ns
module pei_event_irq (
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire logic                  ce,
	input  wire pei_pkg::pei_mgmt_req_s mgmt_req,
	input  wire pei_pkg::pei_events_s   events,
	input  wire logic                  false_carrier_event,
	input  wire logic                  rx_error_count_msb,
	input  wire logic                  powerdown_or_irq_pin_in,
	output logic [15:0]                mgmt_rdata,
	output logic                       mgmt_rvalid,
	output logic [1:0]                 register_page_select,
	output logic                       powerdown_or_irq_pin_out,
	output logic                       powerdown_or_irq_pin_oe,
	output logic                       powerdown_request
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0]  pending_reg;
	logic [7:0]  pending_next;
	logic [7:0]  irq_enable_reg;
	logic [2:0]  control_reg;
	logic [1:0]  page_reg;
	logic [7:0]  fc_count_reg;
	logic [7:0]  fc_count_next;
	logic        rx_msb_reg;
	logic [2:0]  pin_sync_reg;
	logic [7:0]  event_hit;
	logic        rd_status;
	logic        rd_count;
	logic        fc_half_event;
	logic        rx_half_event;
	logic        irq_active;

	assign rd_status = ce && mgmt_req.rd && (mgmt_req.addr == pei_pkg::ADDR_EVENT_STATUS_ENABLE);
	// the counter shares its address with other pages; only page 0 shows it, so only there may a read clear it
	function automatic logic count_page_open(input logic [1:0] page);
		return page == pei_pkg::PAGE_EXTENDED_0;
	endfunction : count_page_open

	assign rd_count  = ce && mgmt_req.rd && (mgmt_req.addr == pei_pkg::ADDR_FALSE_CARRIER_COUNT)
	                   && count_page_open(page_reg); // [RULE9]

	// ----------------------------------------
	// false carrier counter
	// ----------------------------------------
	always_comb begin
		fc_count_next = fc_count_reg;
		if (rd_count) begin
			fc_count_next = '0; // [RULE13]
		end
		// an event in the read cycle is counted in the cleared value, not lost
		if (false_carrier_event) begin
			if (rd_count) begin
				fc_count_next = 8'h01; // [RULE11]
			end else if (fc_count_reg != pei_pkg::COUNT_MAX) begin
				fc_count_next = fc_count_reg + 8'h01; // [RULE11]
			end else begin
				fc_count_next = pei_pkg::COUNT_MAX; // [RULE12]
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fc_count_reg <= '0; // [RULE13]
		end else if (ce) begin
			fc_count_reg <= fc_count_next;
		end
	end

	// half-full on the rising edge of each counter's top bit
	assign fc_half_event = fc_count_next[pei_pkg::COUNT_WIDTH-1] && !fc_count_reg[pei_pkg::COUNT_WIDTH-1]; // [RULE17]
	assign rx_half_event = rx_error_count_msb && !rx_msb_reg; // [RULE17]

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_msb_reg <= 1'b0;
		end else if (ce) begin
			rx_msb_reg <= rx_error_count_msb;
		end
	end

	// ----------------------------------------
	// pending flags
	// ----------------------------------------
	// bit order: lq, ed, link, speed, duplex, autoneg, fc half, rx half
	assign event_hit = {events, fc_half_event, rx_half_event}; // [RULE4] [RULE5] [RULE6]

	always_comb begin
		pending_next = pending_reg;
		if (rd_status) begin
			pending_next = '0; // [RULE7]
		end
		// set wins over the read clear; enables play no part here
		pending_next = pending_next | event_hit; // [RULE1] [RULE3]
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pending_reg <= '0; // [RULE7]
		end else if (ce) begin
			pending_reg <= pending_next;
		end
	end

	// ----------------------------------------
	// writable registers
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_enable_reg <= '0; // [RULE8]
			control_reg    <= '0;
			page_reg       <= pei_pkg::PAGE_EXTENDED_0;
		end else if (ce && mgmt_req.wr) begin
			unique case (mgmt_req.addr)
				pei_pkg::ADDR_EVENT_STATUS_ENABLE: begin
					irq_enable_reg <= mgmt_req.wdata[pei_pkg::NUM_EVENTS-1:0]; // [RULE8]
				end
				pei_pkg::ADDR_INTERRUPT_CONTROL: begin
					control_reg <= mgmt_req.wdata[pei_pkg::CTRL_TEST_FORCE_BIT:0]; // [RULE14] [RULE15] [RULE16]
				end
				pei_pkg::ADDR_REGISTER_PAGE_SELECT: begin
					page_reg <= mgmt_req.wdata[pei_pkg::PAGE_WIDTH-1:0]; // [RULE9] [RULE10]
				end
				default: begin
				end
			endcase
		end
	end

	assign register_page_select = page_reg;

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mgmt_rdata  <= pei_pkg::REG_RESET;
			mgmt_rvalid <= 1'b0;
		end else if (ce) begin
			mgmt_rvalid <= mgmt_req.rd;
			mgmt_rdata  <= pei_pkg::REG_RESET;
			if (mgmt_req.rd) begin
				unique case (mgmt_req.addr)
					pei_pkg::ADDR_EVENT_STATUS_ENABLE: begin
						mgmt_rdata <= {pending_reg, irq_enable_reg}; // [RULE7]
					end
					pei_pkg::ADDR_INTERRUPT_CONTROL: begin
						mgmt_rdata <= {13'h0000, control_reg};
					end
					pei_pkg::ADDR_REGISTER_PAGE_SELECT: begin
						mgmt_rdata <= {14'h0000, page_reg}; // [RULE10]
					end
					pei_pkg::ADDR_FALSE_CARRIER_COUNT: begin
						// other pages belong to blocks outside; read zero here
						if (count_page_open(page_reg)) begin
							mgmt_rdata <= {8'h00, fc_count_reg}; // [RULE13]
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// interrupt and shared pin
	// ----------------------------------------
	assign irq_active = control_reg[pei_pkg::CTRL_TEST_FORCE_BIT] // [RULE15]
	                    || (control_reg[pei_pkg::CTRL_GLOBAL_EN_BIT] && |(pending_reg & irq_enable_reg)); // [RULE2] [RULE14] [RULE18]

	// pin is active low; it floats as power-down input while not enabled as output
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			powerdown_or_irq_pin_out <= 1'b1;
			powerdown_or_irq_pin_oe  <= 1'b0;
		end else if (ce) begin
			powerdown_or_irq_pin_out <= !irq_active;
			powerdown_or_irq_pin_oe  <= control_reg[pei_pkg::CTRL_INT_OE_BIT]; // [RULE16]
		end
	end

	// three-stage sampler; only stages two and three are compared
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_sync_reg <= 3'h7;
		end else if (ce) begin
			pin_sync_reg <= {pin_sync_reg[1:0], powerdown_or_irq_pin_in};
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			powerdown_request <= 1'b0;
		end else if (ce) begin
			if (!control_reg[pei_pkg::CTRL_INT_OE_BIT]) begin
				if (pin_sync_reg[1] == pin_sync_reg[2]) begin
					powerdown_request <= !pin_sync_reg[2]; // [RULE16]
				end
			end else begin
				powerdown_request <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence seq_status_read_quiet;
		ce && rd_status && (event_hit == '0);
	endsequence

	sequence seq_pending_empty;
		pending_reg == '0;
	endsequence

	AST_COR_CLEAR: assert property (@(posedge clock) disable iff (rst) // [RULE7]
		seq_status_read_quiet |=> seq_pending_empty)
		else $error("pending flags not cleared by status read");

	AST_EVENT_SETS: assert property (@(posedge clock) disable iff (rst) // [RULE1] [RULE3]
		ce && events.link_change |=> pending_reg[pei_pkg::EV_LINK_CHANGE])
		else $error("link change event did not set bit 13 flag");

	AST_HALF_FULL: assert property (@(posedge clock) disable iff (rst) // [RULE17] [RULE6]
		ce && !fc_count_reg[pei_pkg::COUNT_WIDTH-1] && fc_count_next[pei_pkg::COUNT_WIDTH-1]
		|=> pending_reg[pei_pkg::EV_FALSE_CARR_HALF])
		else $error("false carrier half-full flag not set");

	AST_FC_INC: assert property (@(posedge clock) disable iff (rst) // [RULE11]
		ce && false_carrier_event && !rd_count && fc_count_reg < pei_pkg::COUNT_MAX
		|=> fc_count_reg == $past(fc_count_reg) + 8'h01)
		else $error("false carrier count did not advance by one");

	AST_FC_STICK: assert property (@(posedge clock) disable iff (rst) // [RULE12]
		ce && fc_count_reg == pei_pkg::COUNT_MAX && !rd_count |=> fc_count_reg == pei_pkg::COUNT_MAX)
		else $error("false carrier count wrapped");

	AST_COUNT_READ: assert property (@(posedge clock) disable iff (rst) // [RULE13]
		ce && rd_count |=> mgmt_rvalid && mgmt_rdata[15:8] == 8'h00 && mgmt_rdata[7:0] == $past(fc_count_reg))
		else $error("count read data wrong");

	AST_PAGE_UPPER: assert property (@(posedge clock) disable iff (rst) // [RULE10]
		ce && mgmt_req.rd && mgmt_req.addr == pei_pkg::ADDR_REGISTER_PAGE_SELECT |=> mgmt_rdata[15:2] == 14'h0000)
		else $error("page register upper bits not zero");

	AST_GATE_OFF: assert property (@(posedge clock) disable iff (rst) // [RULE2] [RULE14]
		ce && !control_reg[pei_pkg::CTRL_GLOBAL_EN_BIT] && !control_reg[pei_pkg::CTRL_TEST_FORCE_BIT]
		|=> powerdown_or_irq_pin_out)
		else $error("interrupt without global enable");

	AST_EN_GATE: assert property (@(posedge clock) disable iff (rst) // [RULE2]
		ce && !control_reg[pei_pkg::CTRL_TEST_FORCE_BIT] && (pending_reg & irq_enable_reg) == '0
		|=> powerdown_or_irq_pin_out)
		else $error("interrupt without an enabled pending flag");

	AST_TEST_FORCE: assert property (@(posedge clock) disable iff (rst) // [RULE15]
		(ce && control_reg[pei_pkg::CTRL_TEST_FORCE_BIT]) [*2] |=> !powerdown_or_irq_pin_out)
		else $error("test interrupt not held");

	AST_IRQ_HOLD: assert property (@(posedge clock) disable iff (rst) // [RULE18]
		ce && control_reg[pei_pkg::CTRL_GLOBAL_EN_BIT] && |(pending_reg & irq_enable_reg)
		|=> !powerdown_or_irq_pin_out)
		else $error("interrupt dropped while enabled flag pending");

	AST_PIN_OE: assert property (@(posedge clock) disable iff (rst) // [RULE16]
		ce |=> powerdown_or_irq_pin_oe == $past(control_reg[pei_pkg::CTRL_INT_OE_BIT]))
		else $error("pin direction does not follow output enable bit");

	AST_ENABLE_WRITE: assert property (@(posedge clock) disable iff (rst) // [RULE8]
		ce && mgmt_req.wr && mgmt_req.addr == pei_pkg::ADDR_EVENT_STATUS_ENABLE
		|=> irq_enable_reg == $past(mgmt_req.wdata[pei_pkg::NUM_EVENTS-1:0]))
		else $error("enable bits did not take the written value");

	AST_PAGE_WRITE: assert property (@(posedge clock) disable iff (rst) // [RULE9]
		ce && mgmt_req.wr && mgmt_req.addr == pei_pkg::ADDR_REGISTER_PAGE_SELECT
		|=> page_reg == $past(mgmt_req.wdata[pei_pkg::PAGE_WIDTH-1:0]))
		else $error("page field did not take the written value");

	// a read through another page must neither show nor clear the counter
	AST_COUNT_HIDDEN: assert property (@(posedge clock) disable iff (rst) // [RULE9]
		ce && mgmt_req.rd && mgmt_req.addr == pei_pkg::ADDR_FALSE_CARRIER_COUNT && !count_page_open(page_reg)
		&& !false_carrier_event |=> mgmt_rdata == pei_pkg::REG_RESET && fc_count_reg == $past(fc_count_reg))
		else $error("count visible or cleared through another page");

endmodule : pei_event_irq

// [bench/pei_mgmt_model.sv]
// station management model: single-cycle register reads and writes on the register port.
// assumes the block answers a read on mgmt_rvalid one cycle after taking it.
`timescale 1ns/1ns
module pei_mgmt_model (
	input  wire logic                   clock,
	output pei_pkg::pei_mgmt_req_s      mgmt_req,
	input  wire logic [15:0]            mgmt_rdata,
	input  wire logic                   mgmt_rvalid
);
	initial mgmt_req = '0;
	// released fields show the inverse so a stale value cannot pass for a held one
	task automatic xfer(input logic r, input logic [4:0] a, input logic [15:0] w, output logic [15:0] d);
		@(posedge clock);
		#1 mgmt_req = '{rd: r, wr: !r, addr: a, wdata: w};
		@(posedge clock);
		#1 mgmt_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~w};
		d = (mgmt_rvalid === 1'b1) ? mgmt_rdata : 16'hXXXX;
	endtask : xfer
endmodule : pei_mgmt_model

// [bench/tb_pei_event_irq.sv]
// self-checking bench of the event status and interrupt block.
// assumes the management model in bench/ and a 100 MHz clock.
`timescale 1ns/1ns
module tb_pei_event_irq;
	logic                   clock = 1'b0;
	logic                   rst = 1'b1;
	logic                   ce = 1'b1;
	pei_pkg::pei_mgmt_req_s mgmt_req;
	pei_pkg::pei_events_s   events = '0;
	logic                   fce = 1'b0;
	logic                   rx_msb = 1'b0;
	logic                   tb_pin = 1'b1;
	logic [15:0]            rdata, d;
	logic                   rvalid, pin_out, pin_oe, pd_req;
	logic [1:0]             page;
	logic [7:0]             en;
	int                     miscompares = 0, checks_done = 0, seed = 7046, n;
	always #5 clock = ~clock;
	pei_event_irq pei_event_irq_i (.clock(clock), .rst(rst), .ce(ce), .mgmt_req(mgmt_req), .events(events),
		.false_carrier_event(fce), .rx_error_count_msb(rx_msb), .powerdown_or_irq_pin_in(pin_oe ? pin_out : tb_pin),
		.mgmt_rdata(rdata), .mgmt_rvalid(rvalid), .register_page_select(page),
		.powerdown_or_irq_pin_out(pin_out), .powerdown_or_irq_pin_oe(pin_oe), .powerdown_request(pd_req));
	pei_mgmt_model pei_mgmt_model_i (.clock(clock), .mgmt_req(mgmt_req), .mgmt_rdata(rdata), .mgmt_rvalid(rvalid));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] exp_cnt(input int k);
		return (k > 255) ? 16'h00FF : 16'(k);
	endfunction : exp_cnt
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [4:0] a, input logic [15:0] w);
		pei_mgmt_model_i.xfer(1'b0, a, w, d);
	endtask : wr
	task automatic chk_rd(input logic [4:0] a, input logic [15:0] exp);
		pei_mgmt_model_i.xfer(1'b1, a, 16'h0000, d);
		check(d, exp);
	endtask : chk_rd
	task automatic tick(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : tick
	task automatic pulse_ev(input int i);
		tick(1);
		events = pei_pkg::pei_events_s'(6'h01 << i);
		tick(1);
		events = '0;
	endtask : pulse_ev
	task automatic fc_pulses(input int k);
		repeat (k) begin
			tick(1);
			fce = 1'b1;
			tick(1);
			fce = 1'b0;
		end
	endtask : fc_pulses
	task automatic final_report;
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		tick(2);
		rst = 1'b0;
		chk_rd(5'h11, 16'h0000);
		chk_rd(5'h12, 16'h0000);
		chk_rd(5'h13, 16'h0000);
		chk_rd(5'h14, 16'h0000);
		chk_rd(5'h1F, 16'h0000);
		$display("test reset done");
		// flags set with random enables while the global enable is off
		for (int i = 0; i < 6; i++) begin
			en = 8'($random(seed));
			wr(5'h12, {8'h00, en});
			pulse_ev(i);
			chk_rd(5'h12, (16'h0400 << i) | {8'h00, en});
			chk_rd(5'h12, {8'h00, en});
		end
		check({15'h0000, pin_oe}, 16'h0000);
		$display("test events done");
		wr(5'h12, 16'h0000);
		wr(5'h13, 16'hFFFF);
		chk_rd(5'h13, 16'h0003);
		wr(5'h13, 16'h0002);
		check({14'h0000, page}, 16'h0002);
		fc_pulses(1);
		chk_rd(5'h14, 16'h0000);
		wr(5'h13, 16'h0000);
		chk_rd(5'h14, 16'h0001);
		$display("test page done");
		n = 1 + ($random(seed) & 63);
		fc_pulses(n);
		chk_rd(5'h14, exp_cnt(n));
		chk_rd(5'h14, 16'h0000);
		fc_pulses(128);
		chk_rd(5'h12, 16'h0200);
		fc_pulses(200);
		chk_rd(5'h14, exp_cnt(328));
		rx_msb = 1'b1;
		chk_rd(5'h12, 16'h0100);
		rx_msb = 1'b0;
		$display("test counter done");
		// clock enable low: events, counts and writes are all lost
		ce = 1'b0;
		pulse_ev(0);
		fc_pulses(1);
		wr(5'h12, 16'h00FF);
		ce = 1'b1;
		chk_rd(5'h12, 16'h0000);
		chk_rd(5'h14, 16'h0000);
		$display("test clock enable done");
		// link change enabled; global enable off first, then on
		wr(5'h12, 16'h0020);
		wr(5'h11, 16'h0001);
		pulse_ev(3);
		tick(2);
		check({14'h0000, pin_oe, pin_out}, 16'h0003);
		wr(5'h11, 16'h0003);
		tick(2);
		check({15'h0000, pin_out}, 16'h0000);
		chk_rd(5'h12, 16'h2020);
		tick(2);
		check({15'h0000, pin_out}, 16'h0001);
		// global enable on, but the link event's own enable off
		wr(5'h12, 16'h00DF);
		pulse_ev(3);
		tick(2);
		check({15'h0000, pin_out}, 16'h0001);
		chk_rd(5'h12, 16'h20DF);
		wr(5'h11, 16'h0005);
		tick(4);
		check({15'h0000, pin_out}, 16'h0000);
		wr(5'h11, 16'h0000);
		tb_pin = 1'b0;
		tick(8);
		check({14'h0000, pin_oe, pd_req}, 16'h0001);
		$display("test interrupt done");
		// mid-run reset returns every register and the pin to idle
		wr(5'h13, 16'h0002);
		wr(5'h12, 16'h00FF);
		wr(5'h11, 16'h0001);
		rst = 1'b1;
		tick(2);
		check({10'h000, page, pin_oe, pin_out, pd_req, rvalid}, 16'h0004);
		rst = 1'b0;
		chk_rd(5'h11, 16'h0000);
		chk_rd(5'h12, 16'h0000);
		chk_rd(5'h13, 16'h0000);
		$display("test mid-run reset done");
		final_report();
	end
	// a hang would stall well beyond the fewer than a thousand cycles the tests need
	initial begin
		#200000;
		miscompares++;
		final_report();
	end
endmodule : tb_pei_event_irq
